/* rtl/licb_config_bank.v */
`timescale 1ns/1ps
`include "licb_defines.vh"

// Overview of operation
// - channel enable bit turns its attenuator on
// - global attenuator enable overrides enable and position
// - position bit set means receive path
// - depth bit set means 128, clear 32
// - global depth control overrides per-channel depth
// - flag set within 4 bits of limit
// - reading flag register clears reported flags
// - disable bit drops short protection per channel
// - global bits override short-disable and AIS settings
// - AIS-on-loss bit sends all-ones during loss
// - PLL input: master clock or recovered clock
// - line-rate output: clock or loss indication
// - aux clock output enabled or high impedance
// - PLL enable bit turns on the PLL
// - PLL off: master clock used directly
// - family bit: set T1 base, clear E1
// - period code gives 1,2,4,8 times base
// - PLL falls back to master clock on loss
module licb_config_bank (
  input  wire                               CLK_SYS_I,
  input  wire                               RST_I,
  // host register port
  input  wire [`LICB_ADDR_W-1:0]            ADDR_I,
  input  wire [`LICB_DATA_W-1:0]            WDATA_I,
  input  wire                               WR_I,
  input  wire                               RD_I,
  output reg  [`LICB_DATA_W-1:0]            RDATA_O,
  output reg                                RVALID_O,
  // global configuration overrides
  input  wire                               GLB_JA_ENABLE_I,
  input  wire                               GLB_JA_POSITION_I,
  input  wire                               GLB_FIFO_DEPTH_OVR_I,
  input  wire                               GLB_FIFO_DEPTH_I,
  input  wire                               GLB_SHORT_PROTECT_DIS_I,
  input  wire                               GLB_AIS_ON_LOSS_I,
  input  wire [2:0]                         PLL_RECOVERED_CLK_SEL_I,
  // datapath status
  input  wire [`LICB_NCH*`LICB_LVL_W-1:0]   FIFO_LEVEL_I,
  input  wire [`LICB_NCH-1:0]               RX_LOS_I,
  input  wire                               LINE_RATE_CLK_I,
  input  wire                               AUX_CLK_I,
  // per-channel controls
  output reg  [`LICB_NCH-1:0]               JA_ENABLE_O,
  output reg  [`LICB_NCH-1:0]               JA_RX_PATH_O,
  output reg  [`LICB_NCH-1:0]               JA_DEEP_FIFO_O,
  output reg  [`LICB_NCH-1:0]               SHORT_PROTECT_DIS_O,
  output reg  [`LICB_NCH-1:0]               AIS_INSERT_O,
  // clock controls
  output reg                                PLL_ENABLE_O,
  output reg                                PLL_SRC_RECOVERED_O,
  output reg  [2:0]                         PLL_RECOVERED_CH_O,
  output reg                                MCLK_DIRECT_O,
  output reg                                MCLK_T1_FAMILY_O,
  output reg  [1:0]                         MCLK_PERIOD_O,
  output wire                               LINE_RATE_PIN_O,
  output wire                               AUX_CLK_O,
  output reg                                AUX_CLK_OE_O
);

  // host-visible registers
  // one byte per function, one bit per channel except the pointer and the clock select; all of them clear on reset
  // so every channel starts with attenuators off, transmit placement, the
  // shallow fifo, short protection active and no AIS on loss
  // the flag register is the only one the host cannot write
  reg  [`LICB_DATA_W-1:0] bank_pointer;
  reg  [`LICB_NCH-1:0]    jitter_atten_enable_ch;
  reg  [`LICB_NCH-1:0]    jitter_atten_position_ch;
  reg  [`LICB_NCH-1:0]    jitter_atten_fifo_depth_ch;
  reg  [`LICB_NCH-1:0]    jitter_atten_fifo_limit_flag;
  reg  [`LICB_NCH-1:0]    short_protect_disable_ch;
  reg  [`LICB_NCH-1:0]    ais_on_loss_ch;
  reg  [`LICB_DATA_W-1:0] master_clock_select_reg;

  // loss pins are asynchronous to the system clock
  reg  [`LICB_NCH-1:0]    los_meta;
  reg  [`LICB_NCH-1:0]    los_sync;
  reg                     rx_loss_indication;

  wire                    indiv_sel;
  wire                    wr_ptr;
  wire                    wr_indiv;
  wire                    rd_limit;
  wire [`LICB_NCH-1:0]    limit_hit;
  wire [`LICB_NCH-1:0]    eff_deep;
  wire [`LICB_NCH-1:0]    next_limit_flag;
  wire                    sel_los;
  reg  [`LICB_DATA_W-1:0] next_rdata;

  // the individual bank is only reachable behind pointer 01
  // the pointer itself sits at the top offset and answers in every bank,
  // otherwise the host could never leave a bank once it had entered it
  // writes to this bank while another bank is selected are dropped here,
  // so a stray access from another bank's driver cannot touch the settings
  // a read of the flag byte is decoded apart because it clears state
  assign indiv_sel = (bank_pointer == `LICB_BANK_INDIV);
  assign wr_ptr    = WR_I && (ADDR_I == `LICB_BANK_PTR_ADDR);
  assign wr_indiv  = WR_I && indiv_sel && (ADDR_I != `LICB_BANK_PTR_ADDR);
  assign rd_limit  = RD_I && indiv_sel && (ADDR_I == `LICB_JA_LIMIT_ADDR);

  // pointer register, shared by every bank
  // any code is stored, even codes of banks that live elsewhere, so that a
  // read-back always returns what was written
  // reset selects the primary bank, never this one
  // limitation: only code 01 opens this bank
  always @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      bank_pointer <= `LICB_RST_BANK;
    end else if (wr_ptr) begin
      bank_pointer <= WDATA_I;
    end
  end

  // writable configuration; bit n-1 holds channel n
  // a write lands at the rising edge that samples the strobe, so a read in
  // the very next cycle already returns the new byte
  // a write and a read in one cycle: the read sees the old value
  // offsets without a register are ignored rather than aliased, which keeps
  // room for later registers without a software-visible change
  // the flag offset is absent on purpose: flags only clear by reading
  always @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      jitter_atten_enable_ch     <= `LICB_RST_BYTE;
      jitter_atten_position_ch   <= `LICB_RST_BYTE;
      jitter_atten_fifo_depth_ch <= `LICB_RST_BYTE;
      short_protect_disable_ch   <= `LICB_RST_BYTE;
      ais_on_loss_ch             <= `LICB_RST_BYTE;
      master_clock_select_reg    <= `LICB_RST_BYTE;
    end else if (wr_indiv) begin
      if (ADDR_I == `LICB_JA_ENABLE_ADDR) begin
        jitter_atten_enable_ch <= WDATA_I;
      end else if (ADDR_I == `LICB_JA_POS_ADDR) begin
        jitter_atten_position_ch <= WDATA_I;
      end else if (ADDR_I == `LICB_JA_DEPTH_ADDR) begin
        jitter_atten_fifo_depth_ch <= WDATA_I;
      end else if (ADDR_I == `LICB_SHORT_DIS_ADDR) begin
        short_protect_disable_ch <= WDATA_I;
      end else if (ADDR_I == `LICB_AIS_LOSS_ADDR) begin
        ais_on_loss_ch <= WDATA_I;
      end else if (ADDR_I == `LICB_MCLK_SEL_ADDR) begin
        // top bit is unused and always reads zero
        master_clock_select_reg <= WDATA_I & `LICB_MC_USED_MASK;
      end
    end
  end

  // two-stage synchroniser for the loss pins
  // loss comes from the receive side and is slow, so two plain flops are
  // enough; only the second stage is read anywhere in this block
  // this costs two cycles of latency, harmless against line rates
  // the first stage is never fanned out, to keep metastability contained
  always @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      los_meta <= `LICB_RST_BYTE;
      los_sync <= `LICB_RST_BYTE;
    end else begin
      los_meta <= RX_LOS_I;
      los_sync <= los_meta;
    end
  end

  // effective depth decides which limit the fill level is compared against
  // the global depth control replaces all eight channel bits at once
  // the same effective depth drives the depth output, so the trip point and
  // the fifo that the datapath builds can never disagree
  assign eff_deep = GLB_FIFO_DEPTH_OVR_I ? {`LICB_NCH{GLB_FIFO_DEPTH_I}} : jitter_atten_fifo_depth_ch;

  // per-channel near-full / near-empty detection
  // each channel slices its own byte out of the packed level bus
  // the top bound is the selected depth, so a channel switched to the
  // shallow fifo trips much earlier than a deep one
  // comparisons are inclusive at both ends
  genvar ch;
  generate
    for (ch = 0; ch < `LICB_NCH; ch = ch + 1) begin : g_limit
      wire [`LICB_LVL_W-1:0] level;
      wire [`LICB_LVL_W-1:0] top;
      assign level = FIFO_LEVEL_I[ch*`LICB_LVL_W +: `LICB_LVL_W];
      assign top   = eff_deep[ch] ? `LICB_DEPTH_DEEP : `LICB_DEPTH_SHALLOW;
      // both ends of the fifo count as a trip
      assign limit_hit[ch] = (level <= `LICB_LIMIT_MARGIN) ||
                             (level >= (top - `LICB_LIMIT_MARGIN));
    end
  endgenerate

  // a read clears only what it returned; a new trip in that cycle survives
  // the set term is or-ed in after the clear, so set wins over clear
  // a fifo that is still near its limit re-arms the flag at once; the host
  // sees it again on the next read, which is the intended behaviour
  // hazard avoided: losing an event that lands on the read cycle
  assign next_limit_flag = (jitter_atten_fifo_limit_flag & ~(rd_limit ? jitter_atten_fifo_limit_flag : `LICB_RST_BYTE))
                           | limit_hit;

  // sticky limit flags
  // updated every cycle so that trips are caught even with no host access
  // reset empties them; nothing else but a read clears a flag
  // flags stay set after the level leaves the trip zone
  always @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      jitter_atten_fifo_limit_flag <= `LICB_RST_BYTE;
    end else begin
      jitter_atten_fifo_limit_flag <= next_limit_flag;
    end
  end

  // read mux; unmapped offsets read zero
  // the pointer reads back in any bank, like it writes
  // with another bank selected every individual offset reads zero, so the
  // host can tell at once that it forgot to set the pointer
  // decode is a priority chain; offsets are disjoint so order is free
  // the default at the top keeps this logic free of latches
  always @* begin
    next_rdata = `LICB_RST_BYTE;
    if (ADDR_I == `LICB_BANK_PTR_ADDR) begin
      next_rdata = bank_pointer;
    end else if (!indiv_sel) begin
      next_rdata = `LICB_RST_BYTE;
    end else if (ADDR_I == `LICB_JA_ENABLE_ADDR) begin
      next_rdata = jitter_atten_enable_ch;
    end else if (ADDR_I == `LICB_JA_POS_ADDR) begin
      next_rdata = jitter_atten_position_ch;
    end else if (ADDR_I == `LICB_JA_DEPTH_ADDR) begin
      next_rdata = jitter_atten_fifo_depth_ch;
    end else if (ADDR_I == `LICB_JA_LIMIT_ADDR) begin
      next_rdata = jitter_atten_fifo_limit_flag;
    end else if (ADDR_I == `LICB_SHORT_DIS_ADDR) begin
      next_rdata = short_protect_disable_ch;
    end else if (ADDR_I == `LICB_AIS_LOSS_ADDR) begin
      next_rdata = ais_on_loss_ch;
    end else if (ADDR_I == `LICB_MCLK_SEL_ADDR) begin
      next_rdata = master_clock_select_reg;
    end
  end

  // read data held until the next read
  // the valid pulse follows the strobe by exactly one cycle
  // holding the data lets a slow host pick it up later than the pulse
  // the byte is captured from the mux at the strobe edge, before any clear
  always @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      RDATA_O  <= `LICB_RST_BYTE;
      RVALID_O <= 1'b0;
    end else begin
      RVALID_O <= RD_I;
      if (RD_I) begin
        RDATA_O <= next_rdata;
      end
    end
  end

  // effective per-channel controls, registered to keep outputs glitch free
  // global overrides win over the per-channel bytes without changing them,
  // so the channel settings come back when an override is dropped
  // the global attenuator enable also takes over the placement
  // AIS always follows the synchronised loss, gated by its enable
  // one cycle of latency from any register or global input change
  always @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      JA_ENABLE_O         <= `LICB_RST_BYTE;
      JA_RX_PATH_O        <= `LICB_RST_BYTE;
      JA_DEEP_FIFO_O      <= `LICB_RST_BYTE;
      SHORT_PROTECT_DIS_O <= `LICB_RST_BYTE;
      AIS_INSERT_O        <= `LICB_RST_BYTE;
    end else begin
      if (GLB_JA_ENABLE_I) begin
        JA_ENABLE_O  <= {`LICB_NCH{1'b1}};
        JA_RX_PATH_O <= {`LICB_NCH{GLB_JA_POSITION_I}};
      end else begin
        JA_ENABLE_O  <= jitter_atten_enable_ch;
        JA_RX_PATH_O <= jitter_atten_position_ch;
      end
      JA_DEEP_FIFO_O <= eff_deep;
      if (GLB_SHORT_PROTECT_DIS_I) begin
        SHORT_PROTECT_DIS_O <= {`LICB_NCH{1'b1}};
      end else begin
        SHORT_PROTECT_DIS_O <= short_protect_disable_ch;
      end
      if (GLB_AIS_ON_LOSS_I) begin
        AIS_INSERT_O <= los_sync;
      end else begin
        AIS_INSERT_O <= ais_on_loss_ch & los_sync;
      end
    end
  end

  // loss on the channel feeding the PLL forces the master clock back in
  // the selected channel comes from the clock control register outside
  // this bank; the choice returns to the receive clock once loss clears
  // limitation: the switch is not hitless, the PLL has to relock
  assign sel_los = los_sync[PLL_RECOVERED_CLK_SEL_I];

  // clock selection controls
  // direct master clock is the reset state, so the device runs without a
  // PLL until the host enables one
  // the period code is forced to zero with the PLL off, where it has no
  // meaning, so the synthesiser never sees a stale multiplier
  // the loss indication is the or of all synchronised loss lines
  always @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      PLL_ENABLE_O        <= 1'b0;
      PLL_SRC_RECOVERED_O <= 1'b0;
      PLL_RECOVERED_CH_O  <= 3'h0;
      MCLK_DIRECT_O       <= 1'b1;
      MCLK_T1_FAMILY_O    <= 1'b0;
      MCLK_PERIOD_O       <= `LICB_PER_DIRECT;
      AUX_CLK_OE_O        <= 1'b0;
      rx_loss_indication  <= 1'b0;
    end else begin
      PLL_ENABLE_O        <= master_clock_select_reg[`LICB_MC_PLL_EN];
      PLL_SRC_RECOVERED_O <= master_clock_select_reg[`LICB_MC_PLL_IN] && !sel_los;
      PLL_RECOVERED_CH_O  <= PLL_RECOVERED_CLK_SEL_I;
      MCLK_DIRECT_O       <= !master_clock_select_reg[`LICB_MC_PLL_EN];
      MCLK_T1_FAMILY_O    <= master_clock_select_reg[`LICB_MC_FREQ_FAM];
      // period code only matters with the PLL running
      if (master_clock_select_reg[`LICB_MC_PLL_EN]) begin
        MCLK_PERIOD_O <= master_clock_select_reg[`LICB_MC_PER_HI:`LICB_MC_PER_LO];
      end else begin
        MCLK_PERIOD_O <= `LICB_PER_DIRECT;
      end
      // outputs are gated only by their own enables; PLL enable is host duty
      AUX_CLK_OE_O       <= master_clock_select_reg[`LICB_MC_AUX_EN];
      rx_loss_indication <= |los_sync;
    end
  end

  // clock paths are plain muxes; a registered copy would halve the clock
  // the select bit is a slow register, so mux glitches only occur when the
  // host switches the output, never in steady operation
  // the aux output is always passed through; its enable decides driving
  assign LINE_RATE_PIN_O = master_clock_select_reg[`LICB_MC_LINE_EN] ? LINE_RATE_CLK_I
                                                                     : rx_loss_indication;
  assign AUX_CLK_O       = AUX_CLK_I;

endmodule // licb_config_bank

/* rtl/licb_defines.vh */
`ifndef LICB_DEFINES_VH
`define LICB_DEFINES_VH

// host port geometry
`define LICB_ADDR_W          5
`define LICB_DATA_W          8
`define LICB_NCH             8
`define LICB_LVL_W           8

// bank pointer codes and location
`define LICB_BANK_PTR_ADDR   5'h1F
`define LICB_BANK_PRIMARY    8'h00
`define LICB_BANK_INDIV      8'h01

// individual bank offsets
`define LICB_JA_ENABLE_ADDR  5'h00
`define LICB_JA_POS_ADDR     5'h01
`define LICB_JA_DEPTH_ADDR   5'h02
`define LICB_JA_LIMIT_ADDR   5'h03
`define LICB_SHORT_DIS_ADDR  5'h04
`define LICB_AIS_LOSS_ADDR   5'h05
`define LICB_MCLK_SEL_ADDR   5'h06

// reset values
`define LICB_RST_BYTE        8'h00
`define LICB_RST_BANK        8'h00

// master clock select fields
`define LICB_MC_PLL_EN       0
`define LICB_MC_FREQ_FAM     1
`define LICB_MC_PER_LO       2
`define LICB_MC_PER_HI       3
`define LICB_MC_AUX_EN       4
`define LICB_MC_LINE_EN      5
`define LICB_MC_PLL_IN       6
`define LICB_MC_USED_MASK    8'h7F
`define LICB_PER_DIRECT      2'h0

// attenuator fifo geometry, in bits
`define LICB_DEPTH_SHALLOW   8'h20
`define LICB_DEPTH_DEEP      8'h80
`define LICB_LIMIT_MARGIN    8'h04

`endif

/* verif/licb_config_bank_chk.sv */
`timescale 1ns/1ps
module licb_config_bank_chk (
  input wire       CLK_SYS_I,
  input wire       RST_I,
  input wire [4:0] ADDR_I,
  input wire [7:0] WDATA_I,
  input wire       WR_I,
  input wire       GLB_JA_ENABLE_I,
  input wire       GLB_JA_POSITION_I,
  input wire       GLB_FIFO_DEPTH_OVR_I,
  input wire       GLB_FIFO_DEPTH_I,
  input wire       GLB_SHORT_PROTECT_DIS_I,
  input wire       GLB_AIS_ON_LOSS_I,
  input wire [7:0] RX_LOS_I,
  input wire       LINE_RATE_CLK_I,
  input wire [7:0] JA_ENABLE_O,
  input wire [7:0] JA_RX_PATH_O,
  input wire [7:0] JA_DEEP_FIFO_O,
  input wire [7:0] SHORT_PROTECT_DIS_O,
  input wire [7:0] AIS_INSERT_O,
  input wire       PLL_ENABLE_O,
  input wire       MCLK_DIRECT_O,
  input wire       MCLK_T1_FAMILY_O,
  input wire [1:0] MCLK_PERIOD_O,
  input wire       LINE_RATE_PIN_O,
  input wire       AUX_CLK_OE_O
);
  reg [7:0] bank;
  reg [7:0] mc;
  // shadow of pointer and clock select, so outputs can be tied to host writes
  always @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      bank <= 8'h00;
      mc   <= 8'h00;
    end else if (WR_I) begin
      if (ADDR_I == 5'h1F) bank <= WDATA_I;
      if (ADDR_I == 5'h06 && bank == 8'h01) mc <= WDATA_I & 8'h7F;
    end
  end
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  property p_en_write;
    (WR_I && ADDR_I == 5'h00 && bank == 8'h01 && !GLB_JA_ENABLE_I) ##1 !GLB_JA_ENABLE_I
      |=> JA_ENABLE_O == $past(WDATA_I, 2);
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable output does not follow write");
  property p_glb_ja;
    GLB_JA_ENABLE_I |=> JA_ENABLE_O == 8'hFF && JA_RX_PATH_O == {8{$past(GLB_JA_POSITION_I)}};
  endproperty
  a_glb_ja: assert property (p_glb_ja) else $error("global attenuator override missing");
  property p_glb_depth;
    GLB_FIFO_DEPTH_OVR_I |=> JA_DEEP_FIFO_O == {8{$past(GLB_FIFO_DEPTH_I)}};
  endproperty
  a_glb_depth: assert property (p_glb_depth) else $error("global depth override missing");
  property p_glb_short;
    GLB_SHORT_PROTECT_DIS_I |=> SHORT_PROTECT_DIS_O == 8'hFF;
  endproperty
  a_glb_short: assert property (p_glb_short) else $error("global short disable missing");
  property p_ais;
    (GLB_AIS_ON_LOSS_I && $stable(RX_LOS_I)) [*5] |-> AIS_INSERT_O == RX_LOS_I;
  endproperty
  a_ais: assert property (p_ais) else $error("ais does not follow loss");
  property p_line;
    mc[5] && $past(mc[5]) |-> LINE_RATE_PIN_O == LINE_RATE_CLK_I;
  endproperty
  a_line: assert property (p_line) else $error("line rate pin not the clock");
  property p_aux;
    $stable(mc) |-> AUX_CLK_OE_O == mc[4];
  endproperty
  a_aux: assert property (p_aux) else $error("aux enable wrong");
  property p_pll;
    $stable(mc) |-> PLL_ENABLE_O == mc[0] && MCLK_DIRECT_O == !mc[0] && MCLK_PERIOD_O == (mc[0] ? mc[3:2] : 2'h0);
  endproperty
  a_pll: assert property (p_pll) else $error("pll controls wrong");
  property p_family;
    $stable(mc) && mc[0] |-> MCLK_T1_FAMILY_O == mc[1];
  endproperty
  a_family: assert property (p_family) else $error("family output wrong");
endmodule // licb_config_bank_chk

bind licb_config_bank licb_config_bank_chk u_chk (.*);

/* verif/liu_individual_config_bank_bench.sv */
`timescale 1ns/1ps
module liu_individual_config_bank_bench;
  reg         clk = 0, rst = 1, wr = 0, rd = 0, lclk = 0, aclk = 0;
  reg         gja = 0, gpos = 0, govr = 0, gdep = 0, gsc = 0, gais = 0;
  reg  [4:0]  addr = 0;
  reg  [7:0]  wdata = 0, los = 0;
  reg  [2:0]  psel = 3'h2;
  reg  [63:0] lvl = {8{8'h10}};
  wire [7:0]  rdata, jen, jrx, jdp, spd, ais;
  wire [2:0]  pch;
  wire [1:0]  per;
  wire        rv, pll, src, dir, t1, lpin, aout, aoe;
  integer     err_count = 0, n_compared = 0, i;
  always #25 clk = ~clk;
  // synthesiser clocks stand in for the real ones, slower than the system clock
  always @(negedge clk) begin
    lclk <= ~lclk;
    aclk <= lclk;
  end
  licb_config_bank DUT (.CLK_SYS_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .RVALID_O(rv), .GLB_JA_ENABLE_I(gja), .GLB_JA_POSITION_I(gpos), .GLB_FIFO_DEPTH_OVR_I(govr),
    .GLB_FIFO_DEPTH_I(gdep), .GLB_SHORT_PROTECT_DIS_I(gsc), .GLB_AIS_ON_LOSS_I(gais), .PLL_RECOVERED_CLK_SEL_I(psel),
    .FIFO_LEVEL_I(lvl), .RX_LOS_I(los), .LINE_RATE_CLK_I(lclk), .AUX_CLK_I(aclk), .JA_ENABLE_O(jen),
    .JA_RX_PATH_O(jrx), .JA_DEEP_FIFO_O(jdp), .SHORT_PROTECT_DIS_O(spd), .AIS_INSERT_O(ais), .PLL_ENABLE_O(pll),
    .PLL_SRC_RECOVERED_O(src), .PLL_RECOVERED_CH_O(pch), .MCLK_DIRECT_O(dir), .MCLK_T1_FAMILY_O(t1),
    .MCLK_PERIOD_O(per), .LINE_RATE_PIN_O(lpin), .AUX_CLK_O(aout), .AUX_CLK_OE_O(aoe));
  task chk(input [7:0] g, input [7:0] e);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task idle(input integer n);
    repeat (n) @(negedge clk);
  endtask
  // one-cycle write strobe, taken at the next rising edge
  task wreg(input [4:0] a, input [7:0] d);
    begin
      @(negedge clk);
      addr = a;
      wdata = d;
      wr = 1;
      @(negedge clk);
      wr = 0;
    end
  endtask
  // read answer lands one cycle after the strobe
  task rreg(input [4:0] a, input [7:0] e);
    begin
      @(negedge clk);
      addr = a;
      rd = 1;
      @(negedge clk);
      rd = 0;
      chk({7'h0, rv}, 8'h01);
      chk(rdata, e);
    end
  endtask
  task end_of_test;
    begin
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  // watchdog, far beyond the roughly 125 cycles the sequence needs
  initial begin
    #200000;
    err_count = err_count + 1;
    end_of_test;
  end
  initial begin
    idle(12);
    rst = 0;
    chk(jen, 8'h00);
    chk({7'h0, dir}, 8'h01);
    wreg(5'h1F, 8'h01);
    for (i = 0; i < 7; i = i + 1) rreg(i[4:0], 8'h00);
    // walking channel bit per register, read straight back
    for (i = 0; i < 6; i = i + 1) if (i != 3) begin
      wreg(i[4:0], 8'hC3 ^ (8'h01 << i));
      rreg(i[4:0], 8'hC3 ^ (8'h01 << i));
    end
    chk(jen, 8'hC2);
    chk(jrx, 8'hC1);
    chk(jdp, 8'hC7);
    chk(spd, 8'hD3);
    wreg(5'h1F, 8'h00);
    wreg(5'h00, 8'hFF);
    rreg(5'h00, 8'h00);
    wreg(5'h1F, 8'h01);
    rreg(5'h00, 8'hC2);
    rreg(5'h0A, 8'h00);
    gja = 1;
    gpos = 1;
    govr = 1;
    gdep = 1;
    gsc = 1;
    idle(2);
    chk(jen, 8'hFF);
    chk(jrx, 8'hFF);
    chk(jdp, 8'hFF);
    chk(spd, 8'hFF);
    rreg(5'h00, 8'hC2);
    gja = 0;
    govr = 0;
    gsc = 0;
    idle(2);
    chk(jen, 8'hC2);
    chk(spd, 8'hD3);
    los = 8'h06;
    idle(4);
    chk(ais, 8'h02);
    gais = 1;
    idle(5);
    chk(ais, 8'h06);
    gais = 0;
    los = 8'h00;
    idle(4);
    chk(ais, 8'h00);
    // ch1 empty edge, ch3 shallow top, ch4 deep top; ch2 deep and ch5 just clear
    wreg(5'h02, 8'h0A);
    idle(1);
    lvl = {8'h10, 8'h10, 8'h10, 8'h05, 8'h7C, 8'h1C, 8'h1C, 8'h04};
    idle(3);
    lvl = {8{8'h10}};
    rreg(5'h03, 8'h0D);
    rreg(5'h03, 8'h00);
    wreg(5'h03, 8'hFF);
    rreg(5'h03, 8'h00);
    wreg(5'h06, 8'hFF);
    rreg(5'h06, 8'h7F);
    chk({7'h0, pll}, 8'h01);
    chk({7'h0, dir}, 8'h00);
    chk({6'h0, per}, 8'h03);
    chk({7'h0, t1}, 8'h01);
    chk({7'h0, src}, 8'h01);
    chk({5'h0, pch}, 8'h02);
    chk({7'h0, aoe}, 8'h01);
    chk({7'h0, lpin}, {7'h0, lclk});
    chk({7'h0, aout}, {7'h0, aclk});
    los = 8'h04;
    idle(4);
    chk({7'h0, src}, 8'h00);
    los = 8'h00;
    idle(4);
    chk({7'h0, src}, 8'h01);
    wreg(5'h06, 8'h0E);
    idle(1);
    chk({6'h0, per}, 8'h00);
    chk({7'h0, dir}, 8'h01);
    chk({7'h0, aoe}, 8'h00);
    chk({7'h0, lpin}, 8'h00);
    los = 8'h80;
    idle(4);
    chk({7'h0, lpin}, 8'h01);
    for (i = 0; i < 4; i = i + 1) begin
      wreg(5'h06, {4'h0, i[1:0], 2'h1});
      idle(1);
      chk({6'h0, per}, i[7:0]);
      chk({7'h0, t1}, 8'h00);
    end
    end_of_test;
  end
endmodule // liu_individual_config_bank_bench
